/* pcecd_regs.svh */
// Register offsets, field positions and reset values of the port C change detector
`ifndef PCECD_REGS_SVH
`define PCECD_REGS_SVH
`define PCECD_OFF_RISE_EN   12'h000
`define PCECD_OFF_FALL_EN   12'h004
`define PCECD_OFF_FLAGS     12'h008
`define PCECD_OFF_INT_CTRL  12'h00C
`define PCECD_OFF_IRQ_STAT  12'h010
`define PCECD_OFF_IRQ_MASK  12'h014
`define PCECD_RST_RISE_EN   8'h00
`define PCECD_RST_FALL_EN   8'h00
`define PCECD_RST_FLAGS     8'h00
`define PCECD_RST_IE        1'b0
`define PCECD_RST_STAT      8'h00
`define PCECD_RST_MASK      8'h00
`define PCECD_BIT_IE        4
`define PCECD_BIT_IF        0
`define PCECD_RESP_OKAY     2'h0
`define PCECD_RESP_SLVERR   2'h2
`endif

/* pcecd_pkg.sv */
// Types shared by the port C change detector
package pcecd_pkg;
  // Write channel states, one-hot
  typedef enum logic [1:0] {
    PCECD_WS_IDLE = 2'b01,
    PCECD_WS_RESP = 2'b10
  } pcecd_wstate_t;
  // Read channel states, one-hot
  typedef enum logic [1:0] {
    PCECD_RS_IDLE = 2'b01,
    PCECD_RS_DATA = 2'b10
  } pcecd_rstate_t;
endpackage : pcecd_pkg

/* pcecd_top.sv */
// Port C pin change detector with AXI4-Lite registers and interrupt
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pcecd_regs.svh"

module pcecd_top
  import pcecd_pkg::*;
#(
  parameter int NPINS = 8                    // Port C pin count
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [NPINS-1:0] portc_pin,
  input  wire logic             sleep_active,
  output logic                  wake_req,
  output logic                  irq,
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // Pin sampling chain
  logic [NPINS-1:0] sync1_q, sync1_d;        // First stage, read only by stage two
  logic [NPINS-1:0] sync2_q, sync2_d;        // Second stage, safe to use
  logic [NPINS-1:0] prev_q, prev_d;          // Previous settled sample
  logic             primed_q, primed_d;      // Zeroes the edge strobes from reset until the first cycle with ce high
  logic [NPINS-1:0] rise_edge, fall_edge;    // One-cycle edge strobes
  logic [NPINS-1:0] hit;                     // Enabled edges this cycle

  // Software visible state
  logic [NPINS-1:0] rise_en_q, rise_en_d;    // portc_rise_enable
  logic [NPINS-1:0] fall_en_q, fall_en_d;    // portc_fall_enable
  logic [NPINS-1:0] flags_q, flags_d;        // portc_change_flags
  logic             ie_q, ie_d;              // change_irq_enable
  logic             change_irq_flag;         // Shared change flag
  logic [NPINS-1:0] stat_q, stat_d;          // Sticky per-pin event status
  logic [NPINS-1:0] mask_q, mask_d;          // Interrupt mask
  logic             wake_q, wake_d;          // Registered wake request

  // Bus side state
  pcecd_wstate_t    wst_q, wst_d;
  pcecd_rstate_t    rst_q, rst_d;
  logic             aw_got_q, aw_got_d;      // Write address captured
  logic             w_got_q, w_got_d;        // Write data captured
  logic [11:0]      waddr_q, waddr_d;
  logic [31:0]      wdata_q, wdata_d;
  logic             wstrb0_q, wstrb0_d;      // Only the low lane holds data
  logic [1:0]       bresp_q, bresp_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [1:0]       rresp_q, rresp_d;
  logic             wr_fire;                 // Write commits this cycle
  logic             rd_fire;                 // Read address taken this cycle
  logic             wr_hit;                  // Write lands on a mapped register
  logic             wr_flags;                // Write to the flag register

  // Handshake outputs straight from state
  assign s_axi_awready = ce && (wst_q == PCECD_WS_IDLE) && !aw_got_q;
  assign s_axi_wready  = ce && (wst_q == PCECD_WS_IDLE) && !w_got_q;
  assign s_axi_bvalid  = (wst_q == PCECD_WS_RESP);
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ce && (rst_q == PCECD_RS_IDLE);
  assign s_axi_rvalid  = (rst_q == PCECD_RS_DATA);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wake_req      = wake_q;

  // Edge detection on settled samples
  always_comb begin
    rise_edge = primed_q ? (sync2_q & ~prev_q) : '0;
    fall_edge = primed_q ? (~sync2_q & prev_q) : '0;
    hit       = (rise_edge & rise_en_q) | (fall_edge & fall_en_q);
    change_irq_flag = |flags_q;
    irq       = |(stat_q & mask_q);
  end

  // Synchroniser next values
  always_comb begin
    sync1_d  = portc_pin;
    sync2_d  = sync1_q;
    prev_d   = sync2_q;
    primed_d = 1'b1;
  end

  // Write channel: address and data in either order
  always_comb begin
    wst_d    = wst_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    wstrb0_d = wstrb0_q;
    bresp_d  = bresp_q;
    wr_fire  = 1'b0;
    case (wst_q)
      PCECD_WS_IDLE: begin
        if (s_axi_awvalid && !aw_got_q) begin
          aw_got_d = 1'b1;
          waddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_q) begin
          w_got_d  = 1'b1;
          wdata_d  = s_axi_wdata;
          wstrb0_d = s_axi_wstrb[0];
        end
        // Commit one cycle after both halves are held
        if (aw_got_q && w_got_q) begin
          wr_fire  = 1'b1;
          aw_got_d = 1'b0;
          w_got_d  = 1'b0;
          bresp_d  = wr_hit ? `PCECD_RESP_OKAY : `PCECD_RESP_SLVERR;
          wst_d    = PCECD_WS_RESP;
        end
      end
      PCECD_WS_RESP: begin
        if (s_axi_bready) begin
          wst_d = PCECD_WS_IDLE;
        end
      end
      default: begin
        wst_d = PCECD_WS_IDLE;
      end
    endcase
  end

  // Address decode for writes
  always_comb begin
    wr_hit   = 1'b1;
    wr_flags = 1'b0;
    if (waddr_q == `PCECD_OFF_RISE_EN) begin
      wr_hit = 1'b1;
    end else if (waddr_q == `PCECD_OFF_FALL_EN) begin
      wr_hit = 1'b1;
    end else if (waddr_q == `PCECD_OFF_FLAGS) begin
      wr_flags = wr_fire && wstrb0_q;
    end else if (waddr_q == `PCECD_OFF_INT_CTRL) begin
      wr_hit = 1'b1;
    end else if (waddr_q == `PCECD_OFF_IRQ_STAT) begin
      wr_hit = 1'b1;                         // Status is read-to-clear; writes ignored
    end else if (waddr_q == `PCECD_OFF_IRQ_MASK) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;                         // Unmapped: answered with an error
    end
  end

  // Register file and flag updates
  always_comb begin
    rise_en_d = rise_en_q;
    fall_en_d = fall_en_q;
    flags_d   = flags_q;
    ie_d      = ie_q;
    mask_d    = mask_q;
    stat_d    = stat_q;
    if (wr_fire && wstrb0_q) begin
      if (waddr_q == `PCECD_OFF_RISE_EN) begin
        rise_en_d = wdata_q[NPINS-1:0];
      end else if (waddr_q == `PCECD_OFF_FALL_EN) begin
        fall_en_d = wdata_q[NPINS-1:0];
      end else if (waddr_q == `PCECD_OFF_INT_CTRL) begin
        ie_d = wdata_q[`PCECD_BIT_IE];
      end else if (waddr_q == `PCECD_OFF_IRQ_MASK) begin
        mask_d = wdata_q[NPINS-1:0];
      end
    end
    // Software write then hardware set: set wins the same cycle
    if (wr_flags) begin
      flags_d = wdata_q[NPINS-1:0];
    end
    flags_d = flags_d | hit;
    // Read of status clears it, fresh events still land
    if (rd_fire && (s_axi_araddr == `PCECD_OFF_IRQ_STAT)) begin
      stat_d = '0;
    end
    stat_d = stat_d | hit;
  end

  // Wake follows the flag: flags_q with this cycle's edges, without this cycle's flag write
  always_comb begin
    wake_d = sleep_active && ie_q && (|(flags_q | hit));
  end

  // Read channel and read data mux
  always_comb begin
    rst_d   = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_fire = 1'b0;
    case (rst_q)
      PCECD_RS_IDLE: begin
        if (s_axi_arvalid) begin
          rd_fire = 1'b1;
          rst_d   = PCECD_RS_DATA;
          rresp_d = `PCECD_RESP_OKAY;
          rdata_d = 32'h0000_0000;
          if (s_axi_araddr == `PCECD_OFF_RISE_EN) begin
            rdata_d[NPINS-1:0] = rise_en_q;
          end else if (s_axi_araddr == `PCECD_OFF_FALL_EN) begin
            rdata_d[NPINS-1:0] = fall_en_q;
          end else if (s_axi_araddr == `PCECD_OFF_FLAGS) begin
            rdata_d[NPINS-1:0] = flags_q;
          end else if (s_axi_araddr == `PCECD_OFF_INT_CTRL) begin
            rdata_d[`PCECD_BIT_IE] = ie_q;
            rdata_d[`PCECD_BIT_IF] = change_irq_flag;
          end else if (s_axi_araddr == `PCECD_OFF_IRQ_STAT) begin
            rdata_d[NPINS-1:0] = stat_q;
          end else if (s_axi_araddr == `PCECD_OFF_IRQ_MASK) begin
            rdata_d[NPINS-1:0] = mask_q;
          end else begin
            rresp_d = `PCECD_RESP_SLVERR;
          end
        end
      end
      PCECD_RS_DATA: begin
        if (s_axi_rready) begin
          rst_d = PCECD_RS_IDLE;
        end
      end
      default: begin
        rst_d = PCECD_RS_IDLE;
      end
    endcase
  end

  // All state registered; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      prev_q    <= '0;
      primed_q  <= 1'b0;
      rise_en_q <= `PCECD_RST_RISE_EN;
      fall_en_q <= `PCECD_RST_FALL_EN;
      flags_q   <= `PCECD_RST_FLAGS;
      ie_q      <= `PCECD_RST_IE;
      stat_q    <= `PCECD_RST_STAT;
      mask_q    <= `PCECD_RST_MASK;
      wake_q    <= 1'b0;
      wst_q     <= PCECD_WS_IDLE;
      rst_q     <= PCECD_RS_IDLE;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      bresp_q   <= `PCECD_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `PCECD_RESP_OKAY;
    end else if (ce) begin
      sync1_q   <= sync1_d;
      sync2_q   <= sync2_d;
      prev_q    <= prev_d;
      primed_q  <= primed_d;
      rise_en_q <= rise_en_d;
      fall_en_q <= fall_en_d;
      flags_q   <= flags_d;
      ie_q      <= ie_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      wake_q    <= wake_d;
      wst_q     <= wst_d;
      rst_q     <= rst_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bresp_q   <= bresp_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Checks on flag behaviour
  property p_fall_sets;
    @(posedge aclk) disable iff (!aresetn)
    (ce && |(fall_edge & fall_en_q)) |=>
      ((flags_q & $past(fall_edge & fall_en_q)) == $past(fall_edge & fall_en_q));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_rise_sets;
    @(posedge aclk) disable iff (!aresetn)
    (ce && |(rise_edge & rise_en_q)) |=>
      ((flags_q & $past(rise_edge & rise_en_q)) == $past(rise_edge & rise_en_q));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_ignore_disabled;
    @(posedge aclk) disable iff (!aresetn)
    (ce && !wr_flags && (hit == '0)) |=> (flags_q == $past(flags_q));
  endproperty
  a_ignore_disabled: assert property (p_ignore_disabled) else $error("flag moved");

  property p_shared_flag;
    @(posedge aclk) disable iff (!aresetn)
    (ce && (hit != '0)) |=> change_irq_flag;
  endproperty
  a_shared_flag: assert property (p_shared_flag) else $error("shared flag low");

  property p_clear_write;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_flags && (hit == '0)) |=> (flags_q == $past(wdata_q[NPINS-1:0]));
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("flag write lost");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_flags && (hit != '0)) |=> ((flags_q & $past(hit)) == $past(hit));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost on clear");

  property p_reset_zero;
    @(posedge aclk) (!aresetn) |=> ((flags_q == '0) && (fall_en_q == '0));
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
    (ce && sleep_active && ie_q && (hit != '0)) |=> (wake_req && (flags_q != '0));
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on change");

  property p_hw_set;
    @(posedge aclk) disable iff (!aresetn)
    (ce && $rose(sync2_q[0]) && primed_q && rise_en_q[0] && !wr_flags) |=>
      flags_q[0];
  endproperty
  a_hw_set: assert property (p_hw_set) else $error("hardware set missing");

  // Shared flag as software sees it must be the OR of the pin flags
  property p_or_flag;
    @(posedge aclk) disable iff (!aresetn)
    (ce && rd_fire && (s_axi_araddr == `PCECD_OFF_INT_CTRL)) |=>
      (s_axi_rdata[`PCECD_BIT_IF] == $past(|flags_q));
  endproperty
  a_or_flag: assert property (p_or_flag) else $error("shared flag not OR");

endmodule : pcecd_top

/* pcecd_pin_model.sv */
// Port C pin driver standing in for the outside world
`timescale 1ns/1ps
module pcecd_pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] want,      // Level the bench asks for
  input  wire logic       slow,      // Answer late when high
  output logic [7:0]      portc_pin  // Pin levels seen by the block
);
  logic [7:0] d1 = 8'h00;  // First delay stage
  logic [7:0] d2 = 8'h00;  // Second delay stage
  logic [7:0] p  = 8'h00;  // Driven level, low at time zero
  // Pins are always driven, so no float pattern is needed
  always @(posedge aclk) begin
    d1 <= want;
    d2 <= d1;
    p  <= slow ? d2 : d1;
  end
  assign portc_pin = p;
endmodule : pcecd_pin_model

/* port_c_edge_change_detect_tb.sv */
// Self-checking bench for the port C change detector
`timescale 1ns/1ps
`include "pcecd_regs.svh"
module port_c_edge_change_detect_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, sleep_active = 1'b0, slow = 1'b0;
  logic [7:0]  want = 8'h00, pins;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, wake_req, irq;
  int          fails = 0, check_count = 0;
  // Free running 50 MHz clock
  always #10 aclk = ~aclk;
  pcecd_pin_model u_pins (.aclk(aclk), .want(want), .slow(slow), .portc_pin(pins));
  pcecd_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .portc_pin(pins),
    .sleep_active(sleep_active), .wake_req(wake_req), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Verdict and end of run
  task automatic summarize;
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Shared compare, counts and reports
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Hung handshake ends the run
  task automatic tmo;
    fails++;
    $display("unexpected at %0t: bus timeout", $time);
    summarize();
  endtask : tmo
  // Write; handshakes sampled mid-cycle, released after the edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b && n < 40) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
    end
    if (!b) tmo();
  endtask : axi_wr
  // Read; rready held until rvalid is seen
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, v;
    n = 0;
    v = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!v && n < 40) begin
      @(negedge aclk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
      n++;
    end
    if (!v) tmo();
  endtask : axi_rd
  // Read and compare data with an OKAY answer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    chk(rd, exp);
    chk(rs, `PCECD_RESP_OKAY);
  endtask : rd_chk
  // Move pins, then allow sync, compare and register to land
  task automatic pins_to(input logic [7:0] v);
    @(posedge aclk);
    want <= v;
    repeat (8) @(posedge aclk);
  endtask : pins_to
  // Reset pulse, all registers zero, unmapped place refused
  task automatic t_reset;
    int i;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) rd_chk(12'(4 * i), 32'h0);
    axi_rd(12'h018, rd, rs);
    chk(rs, `PCECD_RESP_SLVERR);
    axi_wr(12'h018, 32'hFF, rs);
    chk(rs, `PCECD_RESP_SLVERR);
    @(negedge aclk);
    chk({irq, wake_req}, 32'h0);
  endtask : t_reset
  // Rising edges on enabled pins only; falls ignored
  task automatic t_rise;
    axi_wr(`PCECD_OFF_RISE_EN, 32'h3C, rs);
    pins_to(8'hFF);
    rd_chk(`PCECD_OFF_FLAGS, 32'h3C);
    rd_chk(`PCECD_OFF_INT_CTRL, 32'h01);
    axi_wr(`PCECD_OFF_FLAGS, 32'h00, rs);
    rd_chk(`PCECD_OFF_FLAGS, 32'h00);
    pins_to(8'h00);
    rd_chk(`PCECD_OFF_FLAGS, 32'h00);
  endtask : t_rise
  // Falling edges armed per pin, slow pins, partial clear
  task automatic t_fall;
    axi_wr(`PCECD_OFF_RISE_EN, 32'h00, rs);
    axi_wr(`PCECD_OFF_FALL_EN, 32'hA5, rs);
    pins_to(8'hFF);
    rd_chk(`PCECD_OFF_FLAGS, 32'h00);
    slow <= 1'b1;
    pins_to(8'h00);
    rd_chk(`PCECD_OFF_FLAGS, 32'hA5);
    axi_wr(`PCECD_OFF_FLAGS, 32'h21, rs);
    rd_chk(`PCECD_OFF_FLAGS, 32'h21);
    slow <= 1'b0;
  endtask : t_fall
  // Sticky status, mask, read clears, level output
  task automatic t_irq;
    axi_wr(`PCECD_OFF_FALL_EN, 32'h00, rs);
    axi_wr(`PCECD_OFF_FLAGS, 32'h00, rs);
    axi_rd(`PCECD_OFF_IRQ_STAT, rd, rs);
    rd_chk(`PCECD_OFF_IRQ_STAT, 32'h00);
    axi_wr(`PCECD_OFF_IRQ_MASK, 32'h01, rs);
    axi_wr(`PCECD_OFF_RISE_EN, 32'h01, rs);
    pins_to(8'h01);
    @(negedge aclk);
    chk(irq, 1'b1);
    rd_chk(`PCECD_OFF_FLAGS, 32'h01);
    rd_chk(`PCECD_OFF_IRQ_STAT, 32'h01);
    @(negedge aclk);
    chk(irq, 1'b0);
    axi_wr(`PCECD_OFF_RISE_EN, 32'h02, rs);
    pins_to(8'h03);
    @(negedge aclk);
    chk(irq, 1'b0);
    rd_chk(`PCECD_OFF_IRQ_STAT, 32'h02);
    rd_chk(`PCECD_OFF_FLAGS, 32'h03);
  endtask : t_irq
  // Wake request while asleep with change enable set
  task automatic t_wake;
    axi_wr(`PCECD_OFF_INT_CTRL, 32'h10, rs);
    sleep_active <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(wake_req, 1'b1);
    rd_chk(`PCECD_OFF_INT_CTRL, 32'h11);
    axi_wr(`PCECD_OFF_FLAGS, 32'h00, rs);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(wake_req, 1'b0);
    rd_chk(`PCECD_OFF_INT_CTRL, 32'h10);
    sleep_active <= 1'b0;
  endtask : t_wake
  // Main sequence, second reset after the last test
  initial begin
    repeat (2) @(posedge aclk);
    t_reset();
    t_rise();
    t_fall();
    t_irq();
    t_wake();
    t_reset();
    summarize();
  end
endmodule : port_c_edge_change_detect_tb
